// ---- verilog/tcpm_defs.vh ----
// tcpm_defs.vh: offsets, field positions, reset values and codes of the timer
// assumes: included by bare name by every tcpm design file
// Notes on behaviour
// - compare mode with clear select set clears counter on comparator A match.
// - with clear select set, comparator P flag is never raised outside PWM mode.
// - compare mode pin changes only on comparator A match flag or run bit rising edge.
// - run bit rising edge forces pin to initial-level bit in compare mode.
// - mode 11 counts and flags like compare mode but leaves pin undriven.
// - mode 10 makes PWM from both compares and ignores clear select.
// - PWM swap 0 clears on P match; period P*256 or 65536, duty A.
// - PWM swap 1 clears on A match; duty P*256 or 65536.
// - duty at or above period holds output active whole period.
// - PWM mode raises A flag on A match, P flag on P match.
// - PWM polarity from initial level, action field forces or passes, invert.
// - counting and flags keep running while action field forces the pin.
// - 16-bit up-counter stepped by internal clock or external pin edge.
// - compare P matches upper eight counter bits with low byte zero, compare A all sixteen.
// - software cannot load the count; run rising edge only clears it.
// - counter clears on overflow or on the selected comparator match.
// - hold bit 7 freezes count; clearing it resumes from held value.
// - 3-bit clock select: six internal sources, external rising, falling.
// - run bit 3 low stops and keeps count; rising edge zeroes it.
// - count read-only pair, compare A read/write pair, compare P read/write.
// - low three bits of control register 0 always read as zero.
// - invert bit inverts output pin; no effect in timer/counter mode.
`ifndef TCPM_DEFS_VH
`define TCPM_DEFS_VH

`define TCPM_ADDR_W 12
`define TCPM_OFF_CTL0 12'h000
`define TCPM_OFF_CTL1 12'h004
`define TCPM_OFF_CNTL 12'h008
`define TCPM_OFF_CNTH 12'h00c
`define TCPM_OFF_CMPAL 12'h010
`define TCPM_OFF_CMPAH 12'h014
`define TCPM_OFF_CMPP 12'h018
`define TCPM_OFF_FLAGS 12'h01c

`define TCPM_RST_BYTE 8'h00

`define TCPM_C0_HOLD 7
`define TCPM_C0_CKS_HI 6
`define TCPM_C0_CKS_LO 4
`define TCPM_C0_RUN 3
`define TCPM_C0_MASK 8'hf8

`define TCPM_C1_MODE_HI 7
`define TCPM_C1_MODE_LO 6
`define TCPM_C1_IO_HI 5
`define TCPM_C1_IO_LO 4
`define TCPM_C1_OC 3
`define TCPM_C1_POL 2
`define TCPM_C1_DPX 1
`define TCPM_C1_CCLR 0

`define TCPM_FLAG_A 0
`define TCPM_FLAG_P 1

`define TCPM_MODE_CMP 2'b00
`define TCPM_MODE_CAP 2'b01
`define TCPM_MODE_PWM 2'b10
`define TCPM_MODE_TMR 2'b11

`define TCPM_IO_NONE 2'b00
`define TCPM_IO_LOW 2'b01
`define TCPM_IO_HIGH 2'b10
`define TCPM_IO_TOGGLE 2'b11
`define TCPM_PWM_FORCE_OFF 2'b00
`define TCPM_PWM_FORCE_ON 2'b01

`define TCPM_CK_SYS4 3'b000
`define TCPM_CK_SYS 3'b001
`define TCPM_CK_H16 3'b010
`define TCPM_CK_H64 3'b011
`define TCPM_CK_TBC 3'b100
`define TCPM_CK_H8 3'b101
`define TCPM_CK_EXT_RISE 3'b110
`define TCPM_CK_EXT_FALL 3'b111

`define TCPM_SYS4_LAST 2'b11
`define TCPM_H8_LAST 6'h07
`define TCPM_H16_LAST 6'h0f
`define TCPM_H64_LAST 6'h3f

`endif

// ---- verilog/tcpm_clk_sel.v ----
// tcpm_clk_sel: count tick selection and prescaling
// assumes: tick inputs and external pin synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
`include "tcpm_defs.vh"

module tcpm_clk_sel (
  input wire pclk,
  input wire presetn,
  input wire [2:0] clk_select,
  input wire high_clk_tick,
  input wire timebase_clock_tick,
  input wire external_count_input,
  output reg count_tick
);

reg [1:0] sys_div_reg;
reg [5:0] high_div_reg;
reg ext_prev_reg;
reg tick_next;

////////////////////////////////////////////////////////////////////////////
// free running dividers; phase not tied to run bit, so first period
// after start may be short by up to one source period
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    sys_div_reg <= 2'b00;
    high_div_reg <= 6'h00;
    ext_prev_reg <= 1'b0;
  end else begin
    sys_div_reg <= sys_div_reg + 2'b01;
    if (high_clk_tick) begin
      high_div_reg <= high_div_reg + 6'h01;
    end
    ext_prev_reg <= external_count_input;
  end
end

////////////////////////////////////////////////////////////////////////////
always @* begin
  tick_next = 1'b0;
  case (clk_select)
    `TCPM_CK_SYS4: tick_next = (sys_div_reg == `TCPM_SYS4_LAST);
    `TCPM_CK_SYS: tick_next = 1'b1;
    `TCPM_CK_H16: tick_next = high_clk_tick &&
      (high_div_reg[3:0] == `TCPM_H16_LAST);
    `TCPM_CK_H64: tick_next = high_clk_tick &&
      (high_div_reg == `TCPM_H64_LAST);
    `TCPM_CK_TBC: tick_next = timebase_clock_tick;
    `TCPM_CK_H8: tick_next = high_clk_tick &&
      (high_div_reg[2:0] == `TCPM_H8_LAST);
    `TCPM_CK_EXT_RISE: tick_next = external_count_input && !ext_prev_reg;
    `TCPM_CK_EXT_FALL: tick_next = !external_count_input && ext_prev_reg;
    default: tick_next = 1'b0;
  endcase
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    count_tick <= 1'b0;
  end else begin
    count_tick <= tick_next;
  end
end

endmodule // tcpm_clk_sel
`default_nettype wire

// ---- verilog/tcpm_out_ctl.v ----
// tcpm_out_ctl: waveform pin generation for compare and pwm modes
// assumes: match pulses and pwm level come from the counter core
`timescale 1ns/10ps
`default_nettype none
`include "tcpm_defs.vh"

module tcpm_out_ctl (
  input wire pclk,
  input wire presetn,
  input wire [1:0] mode,
  input wire [1:0] out_action,
  input wire initial_level,
  input wire invert,
  input wire run_rise,
  input wire a_flag_event,
  input wire pwm_active,
  output reg timer_output_pin,
  output wire timer_output_enable
);

reg cmp_state_reg;
reg cmp_state_next;
reg raw_level;

////////////////////////////////////////////////////////////////////////////
always @* begin
  cmp_state_next = cmp_state_reg;
  if (run_rise) begin
    cmp_state_next = initial_level;
  end else if (a_flag_event) begin
    case (out_action)
      `TCPM_IO_LOW: cmp_state_next = 1'b0;
      `TCPM_IO_HIGH: cmp_state_next = 1'b1;
      `TCPM_IO_TOGGLE: cmp_state_next = ~cmp_state_reg;
      default: cmp_state_next = cmp_state_reg;
    endcase
  end
end

always @* begin
  raw_level = cmp_state_reg;
  if (mode == `TCPM_MODE_PWM) begin
    // level is active state; initial level picks which polarity is active
    case (out_action)
      `TCPM_PWM_FORCE_OFF: raw_level = ~initial_level;
      `TCPM_PWM_FORCE_ON: raw_level = initial_level;
      default: raw_level = pwm_active ? initial_level : ~initial_level;
    endcase
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    cmp_state_reg <= 1'b0;
    timer_output_pin <= 1'b0;
  end else begin
    cmp_state_reg <= cmp_state_next;
    if (mode == `TCPM_MODE_TMR) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= raw_level ^ invert;
    end
  end
end

// pin released to other use in timer/counter and capture modes
assign timer_output_enable = (mode == `TCPM_MODE_CMP) ||
  (mode == `TCPM_MODE_PWM);

endmodule // tcpm_out_ctl
`default_nettype wire

// ---- verilog/tcpm_top.v ----
// tcpm_top: 16-bit compare/pwm timer with apb register slave
// assumes: apb master in pclk domain, tick and pin inputs synchronous
`timescale 1ns/10ps
`default_nettype none
`include "tcpm_defs.vh"

module tcpm_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire high_clk_tick,
  input wire timebase_clock_tick,
  input wire external_count_input,
  output wire timer_output_pin,
  output wire timer_output_enable,
  output wire compare_a_match_flag,
  output wire compare_p_match_flag
);

////////////////////////////////////////////////////////////////////////////
// register decode

localparam DEC_W = 8;
localparam [DEC_W-1:0] DEC_CTL0 = 8'h01;
localparam [DEC_W-1:0] DEC_CTL1 = 8'h02;
localparam [DEC_W-1:0] DEC_CNTL = 8'h04;
localparam [DEC_W-1:0] DEC_CNTH = 8'h08;
localparam [DEC_W-1:0] DEC_CMPAL = 8'h10;
localparam [DEC_W-1:0] DEC_CMPAH = 8'h20;
localparam [DEC_W-1:0] DEC_CMPP = 8'h40;
localparam [DEC_W-1:0] DEC_FLAGS = 8'h80;
localparam [DEC_W-1:0] DEC_NONE = 8'h00;

// one-hot select of the register at a byte address, none if unmapped
function [DEC_W-1:0] reg_decode;
  input [11:0] addr;
  begin
    case (addr)
      `TCPM_OFF_CTL0: reg_decode = DEC_CTL0;
      `TCPM_OFF_CTL1: reg_decode = DEC_CTL1;
      `TCPM_OFF_CNTL: reg_decode = DEC_CNTL;
      `TCPM_OFF_CNTH: reg_decode = DEC_CNTH;
      `TCPM_OFF_CMPAL: reg_decode = DEC_CMPAL;
      `TCPM_OFF_CMPAH: reg_decode = DEC_CMPAH;
      `TCPM_OFF_CMPP: reg_decode = DEC_CMPP;
      `TCPM_OFF_FLAGS: reg_decode = DEC_FLAGS;
      default: reg_decode = DEC_NONE;
    endcase
  end
endfunction

wire [DEC_W-1:0] sel_dec;
wire setup_phase;
wire wr_access;
wire [DEC_W-1:0] wr_sel;

assign sel_dec = reg_decode(paddr);
assign setup_phase = psel && !penable;
assign wr_access = psel && penable && pwrite;
assign wr_sel = wr_access ? sel_dec : DEC_NONE;

// read data is latched in setup, so every access ends in its first
// access cycle and no wait state is ever inserted
assign pready = 1'b1;
assign pslverr = psel && penable && (sel_dec == DEC_NONE);

////////////////////////////////////////////////////////////////////////////
// software registers

reg [7:0] ctl0_reg;
reg [7:0] ctl1_reg;
reg [15:0] cmp_a_reg;
reg [7:0] cmp_p_reg;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    ctl0_reg <= `TCPM_RST_BYTE;
    ctl1_reg <= `TCPM_RST_BYTE;
    cmp_a_reg <= {`TCPM_RST_BYTE, `TCPM_RST_BYTE};
    cmp_p_reg <= `TCPM_RST_BYTE;
  end else begin
    if (wr_sel == DEC_CTL0) begin
      ctl0_reg <= pwdata[7:0] & `TCPM_C0_MASK;
    end
    if (wr_sel == DEC_CTL1) begin
      ctl1_reg <= pwdata[7:0];
    end
    if (wr_sel == DEC_CMPAL) begin
      cmp_a_reg[7:0] <= pwdata[7:0];
    end
    if (wr_sel == DEC_CMPAH) begin
      cmp_a_reg[15:8] <= pwdata[7:0];
    end
    if (wr_sel == DEC_CMPP) begin
      cmp_p_reg <= pwdata[7:0];
    end
  end
end

wire hold_bit;
wire [2:0] clk_select;
wire run_bit;
wire [1:0] mode;
wire [1:0] out_action;
wire initial_level;
wire invert;
wire swap;
wire clear_select;

assign hold_bit = ctl0_reg[`TCPM_C0_HOLD];
assign clk_select = ctl0_reg[`TCPM_C0_CKS_HI:`TCPM_C0_CKS_LO];
assign run_bit = ctl0_reg[`TCPM_C0_RUN];
assign mode = ctl1_reg[`TCPM_C1_MODE_HI:`TCPM_C1_MODE_LO];
assign out_action = ctl1_reg[`TCPM_C1_IO_HI:`TCPM_C1_IO_LO];
assign initial_level = ctl1_reg[`TCPM_C1_OC];
assign invert = ctl1_reg[`TCPM_C1_POL];
assign swap = ctl1_reg[`TCPM_C1_DPX];
assign clear_select = ctl1_reg[`TCPM_C1_CCLR];

////////////////////////////////////////////////////////////////////////////
// count tick source

wire count_tick;

tcpm_clk_sel u_clk_sel (
  .pclk(pclk),
  .presetn(presetn),
  .clk_select(clk_select),
  .high_clk_tick(high_clk_tick),
  .timebase_clock_tick(timebase_clock_tick),
  .external_count_input(external_count_input),
  .count_tick(count_tick)
);

////////////////////////////////////////////////////////////////////////////
// counter core

reg [15:0] count_reg;
reg [15:0] count_next;
reg run_prev_reg;
wire run_rise;
wire step;
wire [16:0] count_inc;
wire a_hit;
wire p_hit;
wire is_pwm;
reg clear_now;
reg a_event;
reg p_event;

assign run_rise = run_bit && !run_prev_reg;
assign step = count_tick && run_bit && !hold_bit;
assign count_inc = {1'b0, count_reg} + 17'h00001;
// a match when the count reaches the compare value; zero means never,
// so the counter just rolls over without a flag
assign a_hit = (cmp_a_reg != 16'h0000) &&
  (count_inc == {1'b0, cmp_a_reg});
// p matches top byte p with low byte zero; zero matches the roll-over to 65536
assign p_hit = (count_inc[15:0] == {cmp_p_reg, 8'h00}) &&
  ((cmp_p_reg != 8'h00) || count_inc[16]);
assign is_pwm = (mode == `TCPM_MODE_PWM);

always @* begin
  clear_now = 1'b0;
  a_event = 1'b0;
  p_event = 1'b0;
  if (step) begin
    if (is_pwm) begin
      a_event = a_hit;
      p_event = p_hit;
      clear_now = swap ? a_hit : p_hit;
    end else if (clear_select) begin
      a_event = a_hit;
      p_event = 1'b0;
      clear_now = a_hit;
    end else begin
      a_event = a_hit;
      p_event = p_hit;
      clear_now = p_hit;
    end
  end
end

always @* begin
  count_next = count_reg;
  if (run_rise) begin
    count_next = 16'h0000;
  end else if (step) begin
    if (clear_now) begin
      count_next = 16'h0000;
    end else begin
      count_next = count_inc[15:0];
    end
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    count_reg <= 16'h0000;
    run_prev_reg <= 1'b0;
  end else begin
    count_reg <= count_next;
    run_prev_reg <= run_bit;
  end
end

////////////////////////////////////////////////////////////////////////////
// pwm active level

wire [16:0] duty_value;
wire pwm_active;

// swap 1: duty from p, zero meaning a full 65536; swap 0: duty is a.
// duty at or above period never falls below the count, so 100%.
assign duty_value = swap ?
  ((cmp_p_reg == 8'h00) ? 17'h10000 : {1'b0, cmp_p_reg, 8'h00}) :
  {1'b0, cmp_a_reg};
assign pwm_active = ({1'b0, count_reg} < duty_value);

////////////////////////////////////////////////////////////////////////////
// match flags, sticky, write one to clear; a set beats a clear

reg [1:0] flag_reg;
wire [1:0] flag_set;

assign flag_set = {p_event, a_event};

genvar gi;
generate
  for (gi = 0; gi < 2; gi = gi + 1) begin : g_flag
    always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_reg[gi] <= 1'b0;
      end else if (flag_set[gi]) begin
        flag_reg[gi] <= 1'b1;
      end else if ((wr_sel == DEC_FLAGS) && pwdata[gi]) begin
        flag_reg[gi] <= 1'b0;
      end
    end
  end
endgenerate

assign compare_a_match_flag = flag_reg[`TCPM_FLAG_A];
assign compare_p_match_flag = flag_reg[`TCPM_FLAG_P];

////////////////////////////////////////////////////////////////////////////
// waveform pin

tcpm_out_ctl u_out_ctl (
  .pclk(pclk),
  .presetn(presetn),
  .mode(mode),
  .out_action(out_action),
  .initial_level(initial_level),
  .invert(invert),
  .run_rise(run_rise && (mode == `TCPM_MODE_CMP)),
  .a_flag_event(a_event && (mode == `TCPM_MODE_CMP)),
  .pwm_active(pwm_active),
  .timer_output_pin(timer_output_pin),
  .timer_output_enable(timer_output_enable)
);

////////////////////////////////////////////////////////////////////////////
// read path, latched during setup

reg [7:0] rd_byte;

always @* begin
  rd_byte = 8'h00;
  case (sel_dec)
    DEC_CTL0: rd_byte = ctl0_reg & `TCPM_C0_MASK;
    DEC_CTL1: rd_byte = ctl1_reg;
    DEC_CNTL: rd_byte = count_reg[7:0];
    DEC_CNTH: rd_byte = count_reg[15:8];
    DEC_CMPAL: rd_byte = cmp_a_reg[7:0];
    DEC_CMPAH: rd_byte = cmp_a_reg[15:8];
    DEC_CMPP: rd_byte = cmp_p_reg;
    DEC_FLAGS: rd_byte = {6'h00, flag_reg};
    default: rd_byte = 8'h00;
  endcase
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    prdata <= 32'h00000000;
  end else if (setup_phase && !pwrite) begin
    prdata <= {24'h000000, rd_byte};
  end
end

endmodule // tcpm_top
`default_nettype wire

// ---- dv/tcpm_chk.sv ----
// tcpm_chk: port-level checks of the compare/pwm timer
// assumes: bound into tcpm_top; register state mirrored from apb writes
`timescale 1ns/10ps
`default_nettype none
module tcpm_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic high_clk_tick,
  input wire logic timebase_clock_tick,
  input wire logic external_count_input,
  input wire logic timer_output_pin,
  input wire logic timer_output_enable,
  input wire logic compare_a_match_flag,
  input wire logic compare_p_match_flag
);
  ////////////////////////////////////////////////////////////////////////////
  // fresh: run started after last setup write, so count is below period
  logic [7:0] sh_reg [0:7];
  logic fresh_reg;
  logic [3:0] age_reg;
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire hit = paddr[11:5] == 7'h00 && paddr[1:0] == 2'b00;
  wire [2:0] ix = paddr[4:2];
  wire [1:0] md = sh_reg[1][7:6];
  wire [1:0] ac = sh_reg[1][5:4];
  wire oc = sh_reg[1][3];
  wire pol = sh_reg[1][2];
  wire run_up = wr && hit && ix == 3'd0 && pwdata[3] && !sh_reg[0][3];
  wire full = md == 2'b10 && ac[1] && !sh_reg[1][1] && sh_reg[6] != 8'h00
    && {sh_reg[5], sh_reg[4]} >= {sh_reg[6], 8'h00};
  wire p_run = md == 2'b10 && !sh_reg[1][1] && sh_reg[6] == 8'h01
    && sh_reg[0][7:3] == 5'b00011;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++)
        sh_reg[i] <= 8'h00;
      fresh_reg <= 1'b0;
      age_reg <= 4'h0;
    end else begin
      if (run_up)
        age_reg <= 4'h0;
      else if (age_reg != 4'hf)
        age_reg <= age_reg + 4'h1;
      if (wr && hit)
        sh_reg[ix] <= pwdata[7:0];
      if (run_up)
        fresh_reg <= 1'b1;
      else if (wr && hit && ix != 3'd0 && ix != 3'd7)
        fresh_reg <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  enable_by_mode_a: assert property (
    timer_output_enable == (md == 2'b00 || md == 2'b10))
    else $error("output enable does not follow mode");
  no_p_flag_a: assert property (
    md != 2'b10 && sh_reg[1][0] && !compare_p_match_flag
    |=> !compare_p_match_flag)
    else $error("p flag raised with a-clear selected");
  ctl0_low_zero_a: assert property (
    rd && hit && ix == 3'd0 |-> prdata == {24'h0, sh_reg[0] & 8'hf8})
    else $error("control 0 readback wrong");
  readback_a: assert property (
    rd && hit && (ix == 3'd1 || ix >= 3'd4 && ix <= 3'd6)
    |-> prdata == {24'h0, sh_reg[ix]})
    else $error("register readback wrong");
  run_init_a: assert property (
    run_up && md == 2'b00 |-> ##[1:4] timer_output_pin == oc)
    else $error("pin not set to initial level");
  cmp_quiet_a: assert property (
    md == 2'b00 && fresh_reg && age_reg > 4'd4 && !compare_a_match_flag
    ##1 !compare_a_match_flag |-> $stable(timer_output_pin))
    else $error("pin moved without a match");
  pwm_forced_a: assert property (
    md == 2'b10 && !ac[1] && sh_reg[0][3] && $stable(sh_reg[1])
    |=> timer_output_pin == ((ac[0] ? oc : !oc) ^ pol))
    else $error("forced pwm level wrong");
  full_duty_a: assert property (
    full && fresh_reg && age_reg > 4'd4 && $stable(sh_reg[1])
    |-> timer_output_pin == (oc ^ pol))
    else $error("full duty pin not active");
  pwm_p_flag_a: assert property (
    p_run && fresh_reg && age_reg > 4'd4 && !compare_p_match_flag
    |-> ##[1:300] compare_p_match_flag)
    else $error("pwm p match flag missing");
endmodule // tcpm_chk
bind tcpm_top tcpm_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .high_clk_tick(high_clk_tick), .timebase_clock_tick(timebase_clock_tick),
  .external_count_input(external_count_input),
  .timer_output_pin(timer_output_pin),
  .timer_output_enable(timer_output_enable),
  .compare_a_match_flag(compare_a_match_flag),
  .compare_p_match_flag(compare_p_match_flag));
`default_nettype wire

// ---- dv/tcpm_pin_model.sv ----
// tcpm_pin_model: source on the external count pin
// assumes: pclk domain; pin idles low between pulse trains
`timescale 1ns/10ps
`default_nettype none
module tcpm_pin_model (
  input wire logic pclk,
  input wire logic kick,
  input wire logic [7:0] pulses,
  output var logic external_count_input,
  output var logic busy
);
  // pulses three cycles high after three low, slow enough for the edge detector;
  // one process owns both outputs
  initial begin
    external_count_input = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge pclk);
      if (kick) begin
        busy <= 1'b1;
        repeat (pulses) begin
          repeat (3) @(posedge pclk);
          external_count_input <= 1'b1;
          repeat (3) @(posedge pclk);
          external_count_input <= 1'b0;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // tcpm_pin_model
`default_nettype wire

// ---- dv/timer_compare_pwm_module_test.sv ----
// timer_compare_pwm_module_test: register-level tests of the timer
// assumes: tcpm_top with checker bound; tcpm_pin_model on the count pin
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  error_cnt++; $display("wrong value %s exp %0h got %0h", n, e, s); end end
module timer_compare_pwm_module_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, d, v1;
  logic pready, pslverr, serr, ext, pin, oen, af, pf, busy, p;
  logic htick = 0, ttick = 0, kick = 0;
  logic [7:0] npul = 8'h00;
  int error_cnt = 0, check_count = 0, hi, lo, i;
  always #4 pclk = ~pclk;
  always @(posedge pclk) htick <= ~htick;
  always @(posedge pclk) ttick <= htick;
  tcpm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .high_clk_tick(htick), .timebase_clock_tick(ttick),
    .external_count_input(ext), .timer_output_pin(pin),
    .timer_output_enable(oen), .compare_a_match_flag(af),
    .compare_p_match_flag(pf));
  tcpm_pin_model pm (.pclk(pclk), .kick(kick), .pulses(npul),
    .external_count_input(ext), .busy(busy));
  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // stop, program, clear flags, then start so the count begins at zero
  task automatic cfg(input logic [7:0] c1, al, ah, cp);
    bus(1'b1, 12'h000, 8'h00);
    bus(1'b1, 12'h004, c1);
    bus(1'b1, 12'h010, al);
    bus(1'b1, 12'h014, ah);
    bus(1'b1, 12'h018, cp);
    bus(1'b1, 12'h01c, 8'h03);
    bus(1'b1, 12'h000, 8'h18);
    // let the run edge reach the pin before anyone samples it
    repeat (4) @(posedge pclk);
  endtask
  task automatic meas();
    hi = 0;
    lo = 0;
    for (i = 0; i < 3000 && pin !== 1'b0; i++) @(posedge pclk);
    for (i = 0; i < 3000 && pin !== 1'b1; i++) @(posedge pclk);
    while (pin === 1'b1 && hi < 3000) begin
      hi++;
      @(posedge pclk);
    end
    while (pin === 1'b0 && lo < 3000) begin
      lo++;
      @(posedge pclk);
    end
  endtask
  task automatic edges(input int n);
    hi = 0;
    p = pin;
    repeat (n) begin
      @(posedge pclk);
      if (pin !== p)
        hi++;
      p = pin;
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge pclk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 8; k++) begin
      bus(1'b0, 12'(k * 4), 8'h00);
      `CHK("reset value", 32'h0, d)
    end
    // count bytes read only, control 0 low bits absent
    for (int k = 0; k < 7; k++) begin
      bus(1'b1, 12'(k * 4), 8'hff);
      bus(1'b0, 12'(k * 4), 8'h00);
      `CHK("access", (k == 0) ? 32'hf8 : (k == 2 || k == 3) ? 0 : 32'hff, d)
    end
    bus(1'b1, 12'h020, 8'hff);
    `CHK("unmapped", 1'b1, serr)
    cfg(8'h39, 8'h00, 8'h03, 8'h01);
    repeat (4) @(posedge pclk);
    `CHK("initial level", 1'b1, pin)
    meas();
    `CHK("a clear period", 768, hi)
    `CHK("a flag", 1'b1, af)
    `CHK("no p flag", 1'b0, pf)
    cfg(8'h38, 8'h00, 8'h03, 8'h01);
    edges(1000);
    `CHK("pin quiet", 0, hi)
    `CHK("p flag", 1'b1, pf)
    `CHK("a flag", 1'b0, af)
    bus(1'b0, 12'h00c, 8'h00);
    `CHK("count high", 32'h0, d)
    cfg(8'hf9, 8'h00, 8'h01, 8'h00);
    repeat (300) @(posedge pclk);
    `CHK("timer enable", 1'b0, oen)
    `CHK("timer a flag", 1'b1, af)
    cfg(8'ha9, 8'h40, 8'h00, 8'h01);
    meas();
    `CHK("duty", 64, hi)
    `CHK("rest", 192, lo)
    `CHK("pwm flags", 2'b11, {af, pf})
    cfg(8'haf, 8'h00, 8'h03, 8'h01);
    meas();
    `CHK("inverted rest", 512, hi)
    `CHK("inverted duty", 256, lo)
    cfg(8'ha9, 8'h00, 8'h01, 8'h01);
    edges(600);
    `CHK("full duty edges", 0, hi)
    `CHK("full duty pin", 1'b1, pin)
    for (int k = 0; k < 2; k++) begin
      cfg(8'h89 | 8'(k << 4), 8'h40, 8'h00, 8'h01);
      repeat (300) @(posedge pclk);
      `CHK("forced pin", k[0], pin)
      `CHK("forced flags", 2'b11, {af, pf})
    end
    cfg(8'hc1, 8'h00, 8'h00, 8'h00);
    repeat (40) @(posedge pclk);
    bus(1'b1, 12'h000, 8'h98);
    bus(1'b0, 12'h008, 8'h00);
    v1 = d;
    repeat (20) @(posedge pclk);
    bus(1'b0, 12'h008, 8'h00);
    `CHK("held count", v1, d)
    bus(1'b1, 12'h000, 8'h18);
    bus(1'b0, 12'h008, 8'h00);
    `CHK("resumed", 1'b1, d > v1)
    bus(1'b1, 12'h000, 8'h10);
    bus(1'b0, 12'h008, 8'h00);
    v1 = d;
    repeat (20) @(posedge pclk);
    bus(1'b0, 12'h008, 8'h00);
    `CHK("stopped count", v1, d)
    bus(1'b1, 12'h000, 8'h18);
    bus(1'b0, 12'h008, 8'h00);
    `CHK("restart cleared", 1'b1, d < 32'h10)
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, 12'h000, 8'h00);
      bus(1'b1, 12'h000, {1'b0, 3'(k), 4'h8});
      repeat (300) @(posedge pclk);
      bus(1'b0, 12'h008, 8'h00);
      `CHK("internal clock", 1'b1, d != 32'h0)
    end
    for (int k = 6; k < 8; k++) begin
      bus(1'b1, 12'h000, 8'h00);
      bus(1'b1, 12'h000, {1'b0, 3'(k), 4'h8});
      npul <= 8'd9;
      kick <= 1'b1;
      @(posedge pclk);
      kick <= 1'b0;
      @(posedge pclk);
      for (i = 0; i < 3000 && busy === 1'b1; i++) @(posedge pclk);
      repeat (5) @(posedge pclk);
      bus(1'b0, 12'h008, 8'h00);
      `CHK("pin edges counted", 32'd9, d)
    end
    summarize();
  end
endmodule // timer_compare_pwm_module_test
`default_nettype wire
